// File: verilog/spi_port_pkg.sv
// constants, register map and state codes of the spi master port
package spi_port_pkg;
   localparam logic [7:0] ADDR_CLK_DIV = 8'hd2;
   localparam logic [7:0] ADDR_STATUS = 8'hd3;
   localparam logic [7:0] ADDR_TX_HOLD = 8'hd4;
   localparam logic [7:0] ADDR_RX_HOLD = 8'hd5;
   localparam logic [7:0] ADDR_CTRL = 8'hd6;
   localparam logic [7:0] ADDR_IRQ_EN = 8'hd7;

   localparam int unsigned CTRL_TE = 6;
   localparam int unsigned CTRL_RE = 5;
   localparam int unsigned CTRL_EN = 4;
   localparam int unsigned CTRL_SSEL = 3;
   localparam int unsigned CTRL_LSB = 2;
   localparam int unsigned CTRL_SPO = 1;

   localparam int unsigned STAT_BUSY = 4;
   localparam int unsigned FLAG_TEND = 3;
   localparam int unsigned FLAG_ROVR = 2;
   localparam int unsigned FLAG_TEMPTY = 1;
   localparam int unsigned FLAG_RFULL = 0;

   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] CTRL_MASK = 8'h7e;
   localparam logic [7:0] IRQ_EN_RST = 8'h00;
   localparam logic [7:0] IRQ_EN_MASK = 8'h0f;
   localparam logic [7:0] CLK_DIV_RST = 8'h04;
   localparam logic [7:0] CLK_DIV_MASK = 8'hfc;
   localparam logic [3:0] FLAGS_RST = 4'h2;
   localparam logic [7:0] RX_HOLD_RST = 8'h00;

   localparam int unsigned BITS_PER_FRAME = 8;
   localparam int unsigned TX_FIFO_DEPTH = 16;
   localparam int unsigned HALF_W = 7;
   localparam logic [6:0] HALF_MIN = 7'h02;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_LEAD = 4'b0010,
      ST_SHIFT = 4'b0100,
      ST_TRAIL = 4'b1000
   } shift_state_t;
endpackage : spi_port_pkg

// File: verilog/spi_tx_fifo.sv
// transmit holding fifo, flip-flop storage, registered full and empty
`timescale 1ns/1ps
`default_nettype none
module spi_tx_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 16
) (
   input wire logic core_clk, // core clock
   input wire logic resetn, // async reset, active low
   input wire logic in_valid, // push request
   output logic in_ready, // room for a push
   input wire logic [WIDTH-1:0] in_data, // pushed word
   output logic out_valid, // word available
   input wire logic out_ready, // pop request
   output logic [WIDTH-1:0] out_data, // head word
   output logic full_q, // fifo full
   output logic [$clog2(DEPTH+1)-1:0] level_q // words held
);
   localparam int unsigned AW = $clog2(DEPTH);
   localparam int unsigned CW = $clog2(DEPTH+1);

   initial begin
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
         $error("spi_tx_fifo: DEPTH must be a power of two, at least 2");
      end
   end

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_ptr_q;
   logic [AW-1:0] rd_ptr_q;
   logic empty_q;
   logic push;
   logic pop;
   logic [CW-1:0] level_d;

   assign in_ready = ~full_q;
   assign out_valid = ~empty_q;
   assign out_data = mem_q[rd_ptr_q];
   assign push = in_valid & ~full_q;
   assign pop = out_ready & ~empty_q;

   always_comb begin
      level_d = level_q;
      if (push && !pop) begin
         level_d = level_q + CW'(1);
      end else if (pop && !push) begin
         level_d = level_q - CW'(1);
      end
   end

   always_ff @(posedge core_clk) begin
      if (push) begin
         mem_q[wr_ptr_q] <= in_data;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         level_q <= '0;
         full_q <= 1'b0;
         empty_q <= 1'b1;
      end else begin
         if (push) begin
            wr_ptr_q <= wr_ptr_q + AW'(1);
         end
         if (pop) begin
            rd_ptr_q <= rd_ptr_q + AW'(1);
         end
         level_q <= level_d;
         full_q <= (level_d == CW'(DEPTH));
         empty_q <= (level_d == '0);
      end
   end
endmodule : spi_tx_fifo
`default_nettype wire

// File: verilog/spi_rate_divider.sv
// half-period tick generator for the serial clock
`timescale 1ns/1ps
`default_nettype none
module spi_rate_divider #(
   parameter int unsigned HALF_W = 7
) (
   input wire logic core_clk, // core clock
   input wire logic resetn, // async reset, active low
   input wire logic run, // count while high
   input wire logic [HALF_W-1:0] half_cycles, // core cycles per half period
   output logic tick_q // one-cycle pulse per half period
);
   initial begin
      if (HALF_W < 2) begin
         $error("spi_rate_divider: HALF_W too small");
      end
   end

   logic [HALF_W-1:0] cnt_q;

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         cnt_q <= '0;
         tick_q <= 1'b0;
      end else if (!run) begin
         cnt_q <= '0;
         tick_q <= 1'b0;
      end else if (cnt_q >= half_cycles - HALF_W'(1)) begin
         cnt_q <= '0;
         tick_q <= 1'b1;
      end else begin
         cnt_q <= cnt_q + HALF_W'(1);
         tick_q <= 1'b0;
      end
   end
endmodule : spi_rate_divider
`default_nettype wire

// File: verilog/spi_master_port.sv
// master-only spi port with byte-wide special function registers
// Operation
// R1: master only, eight bits out and in together
// R2: gated clock, one period per bit
// R3: shift on one edge, sample on other
// R4: first bit driven at first clock edge
// R5: polarity 0: bit held rising to rising
// R6: polarity 1: bit held falling to falling
// R7: sample on edge where data is valid
// R8: bit order select, same for both directions
// R9: master and slave registers form ring
// R10: transmit and receive paths double buffered
// R11: write-only transmit, read-only receive holding
// R12: full/empty flags, enabled ones raise interrupt
// R13: reset returns whole port to defaults
// R14: serial clock derived from peripheral clock
// R15: divide by sum of selected divisors
// R16: divider resets to divide by four
// R17: single master, no collision detection
// R18: unselected slave ignores clock, floats data
// R19: at most one slave drives input
// R20: lone slave may start on first edge
// R21: auto select low around each byte
// R22: transmitter disabled holds clock idle
// R23: status read clears four cause flags
// R24: pending byte loaded when transfer ends
// R25: received byte copied, receive flagged full
`timescale 1ns/1ps
`default_nettype none
module spi_master_port #(
   parameter int unsigned DATA_W = 8,
   parameter int unsigned FIFO_DEPTH = 16
) (
   input wire logic core_clk, // core and peripheral clock
   input wire logic resetn, // async reset, active low
   input wire logic peripheral_clock_stop, // power-down, peripheral clock halted
   input wire logic [7:0] sfr_addr, // register address
   input wire logic [7:0] sfr_wdata, // write data
   input wire logic sfr_wr, // write strobe
   input wire logic sfr_rd, // read strobe
   output logic [7:0] sfr_rdata_q, // read data, one cycle after strobe
   output logic irq_q, // interrupt request, active high
   output logic tx_fifo_full_q, // transmit holding full
   output logic serial_clock_out_q, // serial clock pin
   output logic serial_out_line_q, // serial data out pin
   input wire logic serial_in_line, // serial data in pin
   output logic peripheral_select_n_q // slave select pin, active low
);
   initial begin
      if (DATA_W != spi_port_pkg::BITS_PER_FRAME || FIFO_DEPTH < 2) begin
         $error("spi_master_port: unsupported DATA_W or FIFO_DEPTH");
      end
   end

   localparam int unsigned CW = $clog2(FIFO_DEPTH+1);
   localparam logic [2:0] LAST_BIT = 3'(spi_port_pkg::BITS_PER_FRAME - 1);

   // divisor is the masked value itself, half of it per clock phase
   function automatic logic [6:0] half_period(input logic [7:0] div);
      logic [6:0] h;
      h = 7'((div & spi_port_pkg::CLK_DIV_MASK) >> 1);
      if (h < spi_port_pkg::HALF_MIN) begin
         h = spi_port_pkg::HALF_MIN;
      end
      return h;
   endfunction : half_period

   function automatic logic sel_bit(input logic [7:0] v, input int unsigned pos);
      return v[pos];
   endfunction : sel_bit

   logic [7:0] ctrl_q;
   logic [7:0] irq_en_q;
   logic [7:0] clk_div_q;
   logic [3:0] flags_q;
   logic [3:0] flags_d;
   logic [3:0] flags_set;
   logic [7:0] rx_hold_q;
   logic rx_unread_q;
   logic [7:0] shift_q;
   logic [2:0] bit_cnt_q;
   logic phase_q;
   logic in_sync1_q;
   logic in_sync2_q;
   spi_port_pkg::shift_state_t state_q;

   logic clock_polarity_sel;
   logic lsb_first;
   logic run_ok;
   logic tick;
   logic frame_done;
   logic load;
   logic wr_tx;
   logic rd_stat;
   logic rd_rx;
   logic fifo_out_valid;
   logic [7:0] fifo_out_data;
   logic [CW-1:0] fifo_level;
   logic fifo_full;

   assign clock_polarity_sel = sel_bit(ctrl_q, spi_port_pkg::CTRL_SPO);
   assign lsb_first = sel_bit(ctrl_q, spi_port_pkg::CTRL_LSB);
   // transfer runs only with port and transmitter on and clock present
   assign run_ok = sel_bit(ctrl_q, spi_port_pkg::CTRL_EN) &
      sel_bit(ctrl_q, spi_port_pkg::CTRL_TE) & ~peripheral_clock_stop; // R14 R22
   assign wr_tx = sfr_wr & (sfr_addr == spi_port_pkg::ADDR_TX_HOLD); // R11
   assign rd_stat = sfr_rd & (sfr_addr == spi_port_pkg::ADDR_STATUS);
   assign rd_rx = sfr_rd & (sfr_addr == spi_port_pkg::ADDR_RX_HOLD);
   assign load = (state_q == spi_port_pkg::ST_IDLE) & run_ok & fifo_out_valid; // R24
   assign frame_done = (state_q == spi_port_pkg::ST_TRAIL) & tick & run_ok;
   assign tx_fifo_full_q = fifo_full;

   spi_tx_fifo #(
      .WIDTH(DATA_W),
      .DEPTH(FIFO_DEPTH)
   ) u_tx_fifo (
      .core_clk(core_clk),
      .resetn(resetn),
      .in_valid(wr_tx),
      .in_ready(),
      .in_data(sfr_wdata),
      .out_valid(fifo_out_valid),
      .out_ready(load),
      .out_data(fifo_out_data),
      .full_q(fifo_full),
      .level_q(fifo_level)
   ); // R10

   spi_rate_divider #(
      .HALF_W(spi_port_pkg::HALF_W)
   ) u_rate (
      .core_clk(core_clk),
      .resetn(resetn),
      .run(run_ok && state_q != spi_port_pkg::ST_IDLE),
      .half_cycles(half_period(clk_div_q)), // R15
      .tick_q(tick)
   );

   // control register writes
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_q <= spi_port_pkg::CTRL_RST; // R13
         irq_en_q <= spi_port_pkg::IRQ_EN_RST;
         clk_div_q <= spi_port_pkg::CLK_DIV_RST; // R16
      end else if (sfr_wr) begin
         case (sfr_addr)
            spi_port_pkg::ADDR_CTRL: ctrl_q <= sfr_wdata & spi_port_pkg::CTRL_MASK;
            spi_port_pkg::ADDR_IRQ_EN: irq_en_q <= sfr_wdata & spi_port_pkg::IRQ_EN_MASK;
            spi_port_pkg::ADDR_CLK_DIV: clk_div_q <= sfr_wdata & spi_port_pkg::CLK_DIV_MASK;
            default: ;
         endcase
      end
   end

   // input synchroniser
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         in_sync1_q <= 1'b0;
         in_sync2_q <= 1'b0;
      end else begin
         in_sync1_q <= serial_in_line;
         in_sync2_q <= in_sync1_q;
      end
   end

   // shift engine; no collision detection, single master only
   always_ff @(posedge core_clk or negedge resetn) begin // R1 R17
      if (!resetn) begin
         state_q <= spi_port_pkg::ST_IDLE;
         shift_q <= '0;
         bit_cnt_q <= '0;
         phase_q <= 1'b0;
         serial_clock_out_q <= 1'b0;
         serial_out_line_q <= 1'b0;
         peripheral_select_n_q <= 1'b1;
      end else if (!run_ok && state_q != spi_port_pkg::ST_IDLE) begin
         state_q <= spi_port_pkg::ST_IDLE;
         serial_clock_out_q <= clock_polarity_sel; // R22
         peripheral_select_n_q <= 1'b1;
      end else begin
         case (state_q)
            spi_port_pkg::ST_IDLE: begin
               serial_clock_out_q <= clock_polarity_sel; // R2
               peripheral_select_n_q <= 1'b1;
               if (load) begin
                  shift_q <= fifo_out_data;
                  bit_cnt_q <= '0;
                  phase_q <= 1'b0;
                  peripheral_select_n_q <= ~sel_bit(ctrl_q, spi_port_pkg::CTRL_SSEL); // R21
                  state_q <= spi_port_pkg::ST_LEAD;
               end
            end
            spi_port_pkg::ST_LEAD: begin
               if (tick) begin
                  state_q <= spi_port_pkg::ST_SHIFT;
               end
            end
            spi_port_pkg::ST_SHIFT: begin
               if (tick && !phase_q) begin
                  // leading edge: drive the next bit
                  serial_clock_out_q <= ~clock_polarity_sel; // R2 R4
                  serial_out_line_q <= lsb_first ? shift_q[0] : shift_q[7]; // R3 R5 R6 R8
                  phase_q <= 1'b1;
               end else if (tick) begin
                  // trailing edge: sample, ring shifts one place
                  serial_clock_out_q <= clock_polarity_sel; // R7
                  if (lsb_first) begin
                     shift_q <= {in_sync2_q, shift_q[7:1]}; // R8 R9
                  end else begin
                     shift_q <= {shift_q[6:0], in_sync2_q}; // R9
                  end
                  phase_q <= 1'b0;
                  bit_cnt_q <= bit_cnt_q + 3'h1;
                  if (bit_cnt_q == LAST_BIT) begin
                     state_q <= spi_port_pkg::ST_TRAIL;
                  end
               end
            end
            spi_port_pkg::ST_TRAIL: begin
               if (tick) begin
                  peripheral_select_n_q <= 1'b1; // R21
                  state_q <= spi_port_pkg::ST_IDLE;
               end
            end
            default: begin
               state_q <= spi_port_pkg::ST_IDLE;
               serial_clock_out_q <= clock_polarity_sel;
               peripheral_select_n_q <= 1'b1;
            end
         endcase
      end
   end

   // receive holding register
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rx_hold_q <= spi_port_pkg::RX_HOLD_RST;
         rx_unread_q <= 1'b0;
      end else if (frame_done && sel_bit(ctrl_q, spi_port_pkg::CTRL_RE)) begin
         rx_hold_q <= shift_q; // R25 R10
         rx_unread_q <= 1'b1;
      end else if (rd_rx) begin
         rx_unread_q <= 1'b0;
      end
   end

   // cause flags: set wins over the read clear
   always_comb begin
      flags_set = '0;
      flags_set[spi_port_pkg::FLAG_TEND] = frame_done & ~fifo_out_valid;
      flags_set[spi_port_pkg::FLAG_ROVR] = frame_done & rx_unread_q &
         sel_bit(ctrl_q, spi_port_pkg::CTRL_RE);
      flags_set[spi_port_pkg::FLAG_TEMPTY] = load & (fifo_level == CW'(1)); // R24
      flags_set[spi_port_pkg::FLAG_RFULL] = frame_done &
         sel_bit(ctrl_q, spi_port_pkg::CTRL_RE); // R25
      flags_d = (flags_q & ~{4{rd_stat}}) | flags_set; // R23
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         flags_q <= spi_port_pkg::FLAGS_RST;
         irq_q <= 1'b0;
      end else begin
         flags_q <= flags_d; // R12
         irq_q <= |(flags_d & irq_en_q[3:0]); // R12
      end
   end

   // register reads
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         sfr_rdata_q <= '0;
      end else if (sfr_rd) begin
         case (sfr_addr)
            spi_port_pkg::ADDR_CTRL: sfr_rdata_q <= ctrl_q;
            spi_port_pkg::ADDR_IRQ_EN: sfr_rdata_q <= irq_en_q;
            spi_port_pkg::ADDR_CLK_DIV: sfr_rdata_q <= clk_div_q;
            spi_port_pkg::ADDR_STATUS: sfr_rdata_q <=
               {3'h0, state_q != spi_port_pkg::ST_IDLE, flags_q};
            spi_port_pkg::ADDR_RX_HOLD: sfr_rdata_q <= rx_hold_q; // R11
            default: sfr_rdata_q <= 8'h00;
         endcase
      end
   end
endmodule : spi_master_port
`default_nettype wire

// File: bench/spi_port_monitor.sv
// checker for pin timing and register reads of the spi master port
`timescale 1ns/1ps
`default_nettype none
module spi_port_monitor (
   input wire logic core_clk, // core clock
   input wire logic resetn, // async reset, active low
   input wire logic peripheral_clock_stop, // power-down
   input wire logic [7:0] sfr_addr, // register address
   input wire logic [7:0] sfr_wdata, // write data
   input wire logic sfr_wr, // write strobe
   input wire logic sfr_rd, // read strobe
   input wire logic [7:0] sfr_rdata_q, // read data
   input wire logic irq_q, // interrupt
   input wire logic tx_fifo_full_q, // fifo full
   input wire logic serial_clock_out_q, // serial clock
   input wire logic serial_out_line_q, // serial data out
   input wire logic serial_in_line, // serial data in
   input wire logic peripheral_select_n_q // select, active low
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!resetn);
   logic [7:0] ctrl_q, irq_en_q, div_q, gap_q, half;
   logic [4:0] edges_q;
   logic clk_prev_q, te, clock_polarity_sel, ssel, sel_n, edge_now;
   assign te = ctrl_q[spi_port_pkg::CTRL_TE];
   assign clock_polarity_sel = ctrl_q[spi_port_pkg::CTRL_SPO];
   assign ssel = ctrl_q[spi_port_pkg::CTRL_SSEL];
   assign sel_n = peripheral_select_n_q;
   assign edge_now = serial_clock_out_q != clk_prev_q;
   // divider zero counts as four
   assign half = (div_q[7:2] == 6'h00) ? 8'h02 : {1'b0, div_q[7:2], 1'b0};
   // shadow copies of the written configuration
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_q <= spi_port_pkg::CTRL_RST;
         irq_en_q <= spi_port_pkg::IRQ_EN_RST;
         div_q <= spi_port_pkg::CLK_DIV_RST;
      end else if (sfr_wr) begin
         if (sfr_addr == spi_port_pkg::ADDR_CTRL) ctrl_q <= sfr_wdata;
         if (sfr_addr == spi_port_pkg::ADDR_IRQ_EN) irq_en_q <= sfr_wdata & spi_port_pkg::IRQ_EN_MASK;
         if (sfr_addr == spi_port_pkg::ADDR_CLK_DIV) div_q <= sfr_wdata;
      end
   end
   // clock edge spacing and edge count within a frame
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         clk_prev_q <= 1'b0;
         gap_q <= 8'h00;
         edges_q <= 5'h00;
      end else begin
         clk_prev_q <= serial_clock_out_q;
         gap_q <= edge_now ? 8'h01 : gap_q + 8'h01;
         if (sel_n) edges_q <= 5'h00;
         else if (edge_now) edges_q <= edges_q + 5'h01;
      end
   end
   property p_te_idle;
      !te && $past(ctrl_q) == ctrl_q && $past(ctrl_q, 2) == ctrl_q |-> serial_clock_out_q == clock_polarity_sel;
   endproperty
   a_te_idle: assert property (p_te_idle) else $error("clock off idle level");
   property p_no_sel;
      !ssel && sel_n |=> sel_n;
   endproperty
   a_no_sel: assert property (p_no_sel) else $error("select fell while disabled");
   property p_gate;
      ssel && sel_n && $past(sel_n) && !peripheral_clock_stop && $past(ctrl_q) == ctrl_q
         && $past(ctrl_q, 2) == ctrl_q |-> !edge_now;
   endproperty
   a_gate: assert property (p_gate) else $error("clock moved between frames");
   property p_frame_edges;
      $rose(sel_n) && te && !peripheral_clock_stop |-> edges_q == 5'h10;
   endproperty
   a_frame_edges: assert property (p_frame_edges) else $error("frame edge count wrong");
   property p_half;
      !sel_n && edge_now && edges_q != 5'h00 |-> gap_q == half;
   endproperty
   a_half: assert property (p_half) else $error("half period wrong");
   sequence s_data_moved;
      !sel_n && $past(!sel_n) && serial_out_line_q != $past(serial_out_line_q);
   endsequence
   property p_data_lead;
      s_data_moved |-> edge_now && serial_clock_out_q != clock_polarity_sel;
   endproperty
   a_data_lead: assert property (p_data_lead) else $error("data moved off lead edge");
   property p_irq_off;
      irq_en_q == 8'h00 && $past(irq_en_q) == 8'h00 |-> !irq_q;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("interrupt while masked");
   property p_tx_read;
      sfr_rd && sfr_addr == spi_port_pkg::ADDR_TX_HOLD |=> sfr_rdata_q == 8'h00;
   endproperty
   a_tx_read: assert property (p_tx_read) else $error("transmit holding readable");
   property p_rdata_hold;
      !sfr_rd |=> $stable(sfr_rdata_q);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
   c_frame: cover property ($rose(sel_n));
   c_irq: cover property ($rose(irq_q));
   c_full: cover property ($rose(tx_fifo_full_q));
endmodule : spi_port_monitor
`default_nettype wire

// File: bench/spi_slave_model.sv
// behavioural spi slave, phase mode one, answers on leading edges
`timescale 1ns/1ps
`default_nettype none
module spi_slave_model (
   input wire logic sclk, // serial clock from master
   input wire logic sel_n, // select, active low
   input wire logic mosi, // master data
   input wire logic pol, // idle level of clock
   input wire logic lsb, // lsb first order
   input wire logic [7:0] load_byte, // byte to return
   output logic miso, // data to master
   output logic [7:0] got_byte // last full byte received
);
   logic [7:0] sh = 8'h00;
   int cnt = 0;
   initial miso = 1'b0;
   initial got_byte = 8'h00;
   always @(negedge sel_n) begin
      sh = load_byte;
      cnt = 0;
   end
   // released line shows the inverse of its last value
   always @(posedge sel_n) miso = ~miso;
   always @(sclk) begin
      if (sel_n === 1'b0) begin
         if (sclk !== pol) miso = lsb ? sh[0] : sh[7];
         else begin
            sh = lsb ? {mosi, sh[7:1]} : {sh[6:0], mosi};
            cnt++;
            if (cnt == 8) got_byte = sh;
         end
      end
   end
endmodule : spi_slave_model
`default_nettype wire

// File: bench/spi_master_port_tb.sv
// self-checking bench for the spi master port with a slave model
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fails++; $display("unexpected at %0t got %h exp %h", $time, (g), (e)); end end
module spi_master_port_tb;
   logic core_clk = 1'b0, resetn = 1'b0, stop = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0;
   logic pol = 1'b0, lsb = 1'b0, sin, sel_n, sclk, sout, irq, full;
   logic [7:0] addr = 8'h00, wdata = 8'h00, sbyte = 8'h00, rdata, got, d;
   logic [23:0] r;
   int fails = 0, checks = 0, cyc = 0;
   logic [23:0] rows [4] = '{24'h78a53c, 24'h7c81c6, 24'h7a1e69, 24'h7e4db2};
   logic [15:0] rst_rows [7] = '{16'hd600, 16'hd700, 16'hd204, 16'hd302, 16'hd500, 16'hd400,
      16'h0000};
   spi_master_port u_spi_master_port (.core_clk(core_clk), .resetn(resetn),
      .peripheral_clock_stop(stop), .sfr_addr(addr), .sfr_wdata(wdata), .sfr_wr(sfr_wr),
      .sfr_rd(sfr_rd), .sfr_rdata_q(rdata), .irq_q(irq), .tx_fifo_full_q(full),
      .serial_clock_out_q(sclk), .serial_out_line_q(sout), .serial_in_line(sin),
      .peripheral_select_n_q(sel_n));
   spi_slave_model u_spi_slave_model (.sclk(sclk), .sel_n(sel_n), .mosi(sout), .pol(pol),
      .lsb(lsb), .load_byte(sbyte), .miso(sin), .got_byte(got));
   always #2.5 core_clk = ~core_clk;
   task automatic test_done();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : test_done
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 10000) begin
         fails++;
         test_done();
      end
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge core_clk);
      addr <= a;
      wdata <= v;
      sfr_wr <= 1'b1;
      @(posedge core_clk);
      sfr_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge core_clk);
      addr <= a;
      sfr_rd <= 1'b1;
      @(posedge core_clk);
      sfr_rd <= 1'b0;
      #1 v = rdata;
   endtask : rd
   task automatic wait_frame();
      int n;
      n = 0;
      // sample mid-cycle: select may stand high for only one cycle between frames
      while (sel_n !== 1'b0 && n < 3000) begin
         @(negedge core_clk);
         n++;
      end
      while (sel_n !== 1'b1 && n < 3000) begin
         @(negedge core_clk);
         n++;
      end
      if (n >= 3000) fails++;
   endtask : wait_frame
   initial begin
      repeat (10) @(posedge core_clk);
      resetn <= 1'b1;
      wr(spi_port_pkg::ADDR_CLK_DIV, 8'h08);
      // polarity and bit order combinations, full exchange each
      for (int i = 0; i < 4; i++) begin
         r = rows[i];
         pol <= r[17];
         lsb <= r[18];
         sbyte <= r[7:0];
         wr(spi_port_pkg::ADDR_CTRL, r[23:16]);
         wr(spi_port_pkg::ADDR_TX_HOLD, r[15:8]);
         wait_frame();
         `CHK(got, r[15:8])
         rd(spi_port_pkg::ADDR_RX_HOLD, d);
         `CHK(d, r[7:0])
         $display("row %0d done", i);
      end
      // fill with transmitter off, one write too many, then drain
      rd(spi_port_pkg::ADDR_STATUS, d);
      wr(spi_port_pkg::ADDR_CTRL, 8'h38);
      pol <= 1'b0;
      lsb <= 1'b0;
      sbyte <= 8'h5a;
      wr(spi_port_pkg::ADDR_IRQ_EN, 8'h0f);
      for (int i = 0; i < 17; i++) wr(spi_port_pkg::ADDR_TX_HOLD, 8'h10 + 8'(i));
      `CHK(full, 1'b1)
      wr(spi_port_pkg::ADDR_CTRL, 8'h78);
      repeat (16) wait_frame();
      repeat (3) @(posedge core_clk);
      `CHK(got, 8'h1f)
      `CHK(full, 1'b0)
      `CHK(irq, 1'b1)
      rd(spi_port_pkg::ADDR_STATUS, d);
      `CHK(d, 8'h0f)
      rd(spi_port_pkg::ADDR_STATUS, d);
      `CHK(d, 8'h00)
      repeat (2) @(posedge core_clk);
      `CHK(irq, 1'b0)
      $display("fill and drain done");
      // power-down in mid frame at a slow rate
      wr(spi_port_pkg::ADDR_CLK_DIV, 8'h24);
      wr(spi_port_pkg::ADDR_TX_HOLD, 8'hc3);
      repeat (80) @(posedge core_clk);
      stop <= 1'b1;
      repeat (4) @(posedge core_clk);
      `CHK(sel_n, 1'b1)
      `CHK(sclk, 1'b0)
      stop <= 1'b0;
      rd(spi_port_pkg::ADDR_RX_HOLD, d);
      `CHK(d, 8'h5a)
      $display("abort done");
      // second reset restores every register
      @(posedge core_clk);
      resetn <= 1'b0;
      repeat (3) @(posedge core_clk);
      `CHK(sel_n, 1'b1)
      resetn <= 1'b1;
      for (int i = 0; i < 7; i++) begin
         rd(rst_rows[i][15:8], d);
         `CHK(d, rst_rows[i][7:0])
      end
      $display("reset values done");
      test_done();
   end
endmodule : spi_master_port_tb
bind spi_master_port spi_port_monitor u_spi_port_monitor (.core_clk(core_clk), .resetn(resetn),
   .peripheral_clock_stop(peripheral_clock_stop), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
   .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata_q(sfr_rdata_q), .irq_q(irq_q),
   .tx_fifo_full_q(tx_fifo_full_q), .serial_clock_out_q(serial_clock_out_q),
   .serial_out_line_q(serial_out_line_q), .serial_in_line(serial_in_line),
   .peripheral_select_n_q(peripheral_select_n_q));
`default_nettype wire
